// ==== inc/io_window_defines.svh ====
// Constants of the I/O window decoder: mode switch fields, timing, fixed sizes.
// Assumes a 100 MHz ref_clk; included by bare name.
`ifndef IO_WINDOW_DEFINES_SVH
`define IO_WINDOW_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define SELFTEST_NS 1000
`define SELFTEST_CYCLES ((`SELFTEST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_CTRL_BIT 0
`define MODE_FREE_BIT 1
`define COMM_WORDS 2
`define DIAG_BELOW 1
`endif

// ==== inc/io_window_pkg.sv ====
// Types shared by the I/O window decoder.
// No assumptions beyond a SystemVerilog compiler.
`default_nettype none
package io_window_pkg;
	typedef enum logic [2:0] {
		ST_SELFTEST = 3'b000,
		ST_READY = 3'b001,
		ST_ADDRESS = 3'b010,
		ST_STORE = 3'b011,
		ST_RUN = 3'b100
	} state_t;
endpackage
`default_nettype wire

// ==== verilog/io_window_ack_decoder.sv ====
// Address-window decode and acknowledge for a fieldbus board on a PLC I/O backplane.
// Assumes switches static, address entries from the fieldbus side, one clock.
`timescale 1ns/1ps
`default_nettype none
`include "io_window_defines.svh"
module io_window_ack_decoder
	import io_window_pkg::*;
#(
	parameter int AW = 12,
	parameter int N = 16,
	parameter int SELFTEST_CYC = `SELFTEST_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [1:0] mode_select_switch,
	input wire logic [AW-1:0] window1_base_switch,
	input wire logic [AW-1:0] window1_length_switch,
	input wire logic [AW-1:0] window2_base_switch,
	input wire logic [AW-1:0] window2_length_switch,
	input wire logic [AW-1:0] comm_register_base_switch,
	input wire logic seq_from_card,
	input wire logic entry_valid,
	input wire logic entry_src_card,
	input wire logic entry_last,
	input wire logic entry_window,
	input wire logic entry_logical,
	input wire logic [7:0] entry_words,
	input wire logic [AW-1:0] entry_base,
	input wire logic host_sel,
	input wire logic [AW-1:0] host_addr,
	output logic entry_ready,
	output logic ready_ind,
	output logic run_ind,
	output logic nvm_we,
	output logic [$clog2(N+1)-1:0] nvm_index,
	output logic [AW-1:0] nvm_data,
	output logic host_ack,
	output logic cfg_error,
	output logic window_overflow
);
	localparam int IW = $clog2(N+1);
	localparam int CW = $clog2(SELFTEST_CYC+1);

	typedef struct packed {
		state_t st;
		logic [CW-1:0] cnt;
		logic ctrl;
		logic free;
		logic card;
		logic [AW-1:0] w1b;
		logic [AW-1:0] w1l;
		logic [AW-1:0] w2b;
		logic [AW-1:0] w2l;
		logic [AW-1:0] cb;
		logic [AW-1:0] used1;
		logic [AW-1:0] used2;
		logic [N-1:0] vld;
		logic [N-1:0][AW-1:0] base;
		logic [N-1:0][AW-1:0] top;
		logic [IW-1:0] n;
		logic [IW-1:0] widx;
		logic [IW-1:0] nidx;
		logic [AW-1:0] wdata;
		logic we;
		logic erdy;
		logic rdy;
		logic run;
		logic ack;
		logic err;
		logic ovf;
	} regs_t;

	regs_t q;
	regs_t d;
	logic [N-1:0] ent_hit;
	logic win1_hit;
	logic win2_hit;
	logic comm_hit;
	logic diag_hit;
	logic hit;
	logic [AW-1:0] pbase;
	logic [AW-1:0] ptop;
	logic accept;

	// Per-entry decode of the defined areas
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_ent
			assign ent_hit[gi] = q.vld[gi] && host_addr >= q.base[gi] && host_addr < q.top[gi];
		end
	endgenerate

	always_comb begin
		comm_hit = host_addr == q.cb || host_addr == q.cb + AW'(`COMM_WORDS - 1);
		diag_hit = !q.ctrl && (host_addr == q.w1b - AW'(`DIAG_BELOW) ||
			host_addr == q.w2b - AW'(`DIAG_BELOW));
		if (q.free && !q.ctrl) begin
			// Only the space the modules really use
			win1_hit = host_addr >= q.w1b && host_addr < q.w1b + q.used1;
			win2_hit = host_addr >= q.w2b && host_addr < q.w2b + q.used2;
		end else if (!q.free) begin
			win1_hit = host_addr >= q.w1b && host_addr < q.w1b + q.w1l;
			win2_hit = host_addr >= q.w2b && host_addr < q.w2b + q.w2l;
		end else begin
			// Controlled free: window switches are not relevant
			win1_hit = 1'b0;
			win2_hit = 1'b0;
		end
		hit = comm_hit || diag_hit || win1_hit || win2_hit || (q.ctrl && |ent_hit);
	end

	assign accept = q.st == ST_ADDRESS && q.erdy && entry_valid;
	assign pbase = entry_window ? q.w2b + q.used2 : q.w1b + q.used1;
	assign ptop = pbase + AW'(entry_words);

	always_comb begin
		d = q;
		d.we = 1'b0;
		d.ack = q.run && host_sel && hit;
		case (q.st)
			ST_SELFTEST: begin
				if (q.cnt == '0) begin
					d.ctrl = mode_select_switch[`MODE_CTRL_BIT];
					d.free = mode_select_switch[`MODE_FREE_BIT];
					d.card = seq_from_card;
					d.w1b = window1_base_switch;
					d.w1l = window1_length_switch;
					d.w2b = window2_base_switch;
					d.w2l = window2_length_switch;
					d.cb = comm_register_base_switch;
				end
				if (q.cnt == CW'(SELFTEST_CYC - 1)) begin
					d.st = ST_READY;
					d.rdy = 1'b1;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
			ST_READY: begin
				d.st = ST_ADDRESS;
				d.erdy = 1'b1;
			end
			ST_ADDRESS: begin
				if (accept) begin
					// In controlled modes, entries from the unselected source are dropped
					if (!q.ctrl || entry_src_card == q.card) begin
						if (q.ctrl && entry_logical) begin
							if (q.free && entry_base[0]) begin
								d.err = 1'b1;
							end else if (q.n < IW'(N)) begin
								d.vld[q.n[IW-2:0]] = 1'b1;
								d.base[q.n[IW-2:0]] = entry_base;
								d.top[q.n[IW-2:0]] = entry_base + AW'(entry_words);
								d.n = q.n + 1'b1;
								if (!q.free && !((entry_base >= q.w1b &&
									entry_base + AW'(entry_words) <= q.w1b + q.w1l) ||
									(entry_base >= q.w2b &&
									entry_base + AW'(entry_words) <= q.w2b + q.w2l)))
									d.err = 1'b1;
							end else begin
								d.err = 1'b1;
							end
						end else if (q.n < IW'(N)) begin
							// Physical order: consecutive from the window base
							d.vld[q.n[IW-2:0]] = 1'b1;
							d.base[q.n[IW-2:0]] = pbase;
							d.top[q.n[IW-2:0]] = ptop;
							d.n = q.n + 1'b1;
							if (entry_window) begin
								d.used2 = q.used2 + AW'(entry_words);
								if (q.used2 + AW'(entry_words) > q.w2l)
									d.ovf = 1'b1;
							end else begin
								d.used1 = q.used1 + AW'(entry_words);
								if (q.used1 + AW'(entry_words) > q.w1l)
									d.ovf = 1'b1;
							end
						end else begin
							d.err = 1'b1;
						end
					end
					if (entry_last) begin
						d.erdy = 1'b0;
						d.st = ST_STORE;
						d.widx = '0;
					end
				end
			end
			ST_STORE: begin
				// One non-volatile write per address, then run
				if (q.widx < q.n) begin
					d.we = 1'b1;
					d.wdata = q.base[q.widx[IW-2:0]];
					// Index kept in its own flop so the output port is registered
					d.nidx = q.widx;
					d.widx = q.widx + 1'b1;
				end else begin
					d.st = ST_RUN;
					d.run = 1'b1;
				end
			end
			ST_RUN: begin
				d.st = ST_RUN;
			end
			default: begin
				d.st = ST_SELFTEST;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign entry_ready = q.erdy;
	assign ready_ind = q.rdy;
	assign run_ind = q.run;
	assign nvm_we = q.we;
	assign nvm_index = q.nidx;
	assign nvm_data = q.wdata;
	assign host_ack = q.ack;
	assign cfg_error = q.err;
	assign window_overflow = q.ovf;

	ack_in_run_a: assert property (@(posedge ref_clk) disable iff (rst)
		host_ack |-> run_ind && $past(host_sel))
		else $error("acknowledge outside cyclic operation");
	no_sel_ack_a: assert property (@(posedge ref_clk) disable iff (rst)
		!host_sel |=> !host_ack)
		else $error("acknowledge without access");
	comm_ack_a: assert property (@(posedge ref_clk) disable iff (rst)
		run_ind && host_sel && (host_addr == q.cb || host_addr == q.cb + AW'(1)) |=> host_ack)
		else $error("communication register not acknowledged");
	diag_below_a: assert property (@(posedge ref_clk) disable iff (rst)
		run_ind && !q.ctrl && host_sel && host_addr == q.w2b - AW'(1) |=> host_ack)
		else $error("diagnostic register not acknowledged");
	fixed_win_a: assert property (@(posedge ref_clk) disable iff (rst)
		run_ind && !q.free && host_sel && host_addr >= q.w1b &&
		host_addr < q.w1b + q.w1l |=> host_ack)
		else $error("fixed window address not acknowledged");
	mode_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		q.st != ST_SELFTEST |=> $stable(q.ctrl) && $stable(q.free) && $stable(q.w1b))
		else $error("mode changed after reset");
	odd_base_a: assert property (@(posedge ref_clk) disable iff (rst)
		accept && q.ctrl && q.free && entry_logical && entry_base[0] &&
		entry_src_card == q.card |=> cfg_error)
		else $error("odd base not flagged");
	store_before_run_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(run_ind) |-> $past(q.st) == ST_STORE && ready_ind)
		else $error("run without store phase");
	ready_time_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(ready_ind) |-> $past(q.cnt) == CW'(SELFTEST_CYC - 1))
		else $error("ready before selftest done");
	run_cov: cover property (@(posedge ref_clk) disable iff (rst) $rose(run_ind));
	ack_cov: cover property (@(posedge ref_clk) disable iff (rst) host_ack && q.free);
	store_cov: cover property (@(posedge ref_clk) disable iff (rst) nvm_we ##1 nvm_we);
	err_cov: cover property (@(posedge ref_clk) disable iff (rst) $rose(cfg_error));
endmodule
`default_nettype wire

// ==== dv/host_model.sv ====
// Host CPU model: issues one-cycle word accesses on the backplane I/O bus.
// Assumes the bench calls access() from its main process, one at a time.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic ref_clk,
	output logic host_sel,
	output logic [11:0] host_addr
);
	initial begin
		host_sel = 1'b0;
		host_addr = 12'h000;
	end
	// Every address passed in goes out with the strobe; released address is inverted, not held
	task automatic access(input logic [11:0] a);
		@(posedge ref_clk);
		host_sel <= 1'b1;
		host_addr <= a;
		@(posedge ref_clk);
		host_sel <= 1'b0;
		host_addr <= ~a;
	endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Bench for the I/O window decoder: boots all four start/addressing modes, probes acks.
// Assumes the host model drives the backplane strobe; entries and switches driven here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic hit = 1'b1;
	localparam logic miss = 1'b0;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] msw = 2'b00;
	logic card = 1'b0;
	logic [11:0] cb = 12'h800;
	logic [11:0] w1b = 12'h100;
	logic [11:0] w1l = 12'h010;
	logic [11:0] w2b = 12'h200;
	logic [11:0] w2l = 12'h010;
	logic ev = 1'b0, ewin = 1'b0, elog = 1'b0, esrc = 1'b0, elast = 1'b0;
	logic [7:0] ewords = 8'h00;
	logic [11:0] ebase = 12'h000;
	logic erdy, rdy, run, nvm_we, ack, cfg_err, ovf, sel, pend = 1'b0;
	logic [4:0] nidx;
	logic [4:0] nk;
	logic [11:0] ndata, haddr;
	int num_errors = 0;
	int checks = 0;
	logic exp_ack[$];
	logic [16:0] exp_nvm[$];
	always #5 ref_clk = ~ref_clk;
	io_window_ack_decoder #(.SELFTEST_CYC(4)) uut (.ref_clk(ref_clk), .rst(rst),
		.mode_select_switch(msw), .window1_base_switch(w1b),
		.window1_length_switch(w1l), .window2_base_switch(w2b),
		.window2_length_switch(w2l), .comm_register_base_switch(cb),
		.seq_from_card(card), .entry_valid(ev), .entry_src_card(esrc), .entry_last(elast),
		.entry_window(ewin), .entry_logical(elog), .entry_words(ewords), .entry_base(ebase),
		.host_sel(sel), .host_addr(haddr), .entry_ready(erdy), .ready_ind(rdy),
		.run_ind(run), .nvm_we(nvm_we), .nvm_index(nidx), .nvm_data(ndata),
		.host_ack(ack), .cfg_error(cfg_err), .window_overflow(ovf));
	host_model hm (.ref_clk(ref_clk), .host_sel(sel), .host_addr(haddr));
	task automatic fail(input logic [16:0] e, input logic [16:0] g);
		num_errors++;
		$display("[ERR] %0t exp=%h got=%h", $time, e, g);
	endtask
	task automatic cmp_ack(input logic e, input logic g);
		checks++;
		if (g !== e) fail({16'h0, e}, {16'h0, g});
	endtask
	task automatic cmp_flag(input logic e, input logic g);
		checks++;
		if (g !== e) fail({16'h0, e}, {16'h0, g});
	endtask
	task automatic cmp_nvm(input logic [16:0] e, input logic [16:0] g);
		checks++;
		if (g !== e) fail(e, g);
	endtask
	task automatic close_out();
		if (exp_ack.size() != 0 || exp_nvm.size() != 0) num_errors++;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Looked at mid-cycle, where registered outputs have settled; ack answers
	// the strobe seen half a cycle before the previous rising edge
	always @(negedge ref_clk) begin
		if (pend) cmp_ack(exp_ack.size() ? exp_ack.pop_front() : 1'bx, ack);
		pend = sel;
		if (nvm_we) cmp_nvm(exp_nvm.size() ? exp_nvm.pop_front() : 17'bx, {nidx, ndata});
	end
	// A timeout counts a mismatch and returns; every later wait is bounded too
	task automatic wait_for(input logic on_run);
		int i;
		i = 0;
		#1;
		while ((on_run ? run : erdy) !== 1'b1 && i <= 200) begin
			@(posedge ref_clk);
			#1;
			i++;
		end
		if (i > 200) num_errors++;
	endtask
	task automatic boot(input logic [1:0] m, input logic c);
		@(posedge ref_clk);
		rst <= 1'b1;
		msw <= m;
		card <= c;
		w1b <= 12'h100;
		cb <= 12'h800 | 12'($urandom() & 32'hff);
		nk = 5'd0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		wait_for(1'b0);
		cmp_flag(1'b1, rdy);
		cmp_flag(1'b0, run);
	endtask
	// f = {stored, window, logical, from card, last}; d = base expected in memory
	task automatic send(input logic [4:0] f, input logic [7:0] n, input logic [11:0] b,
		input logic [11:0] d);
		if (f[4]) begin
			exp_nvm.push_back({nk, d});
			nk++;
		end
		@(posedge ref_clk);
		ev <= 1'b1;
		ewin <= f[3];
		elog <= f[2];
		esrc <= f[1];
		elast <= f[0];
		ewords <= n;
		ebase <= f[2] ? b : 12'($urandom());
		wait_for(1'b0);
		@(posedge ref_clk);
		ev <= 1'b0;
	endtask
	task automatic probe(input logic [11:0] a, input logic e);
		exp_ack.push_back(e);
		hm.access(a);
	endtask
	// w2 = words of the window 2 module; above the window length it overflows
	task automatic phys3(input logic [7:0] w2);
		send(5'b10000, 8'd2, 12'h000, 12'h100);
		send(5'b10000, 8'd3, 12'h000, 12'h102);
		send(5'b11001, w2, 12'h000, 12'h200);
		wait_for(1'b1);
		cmp_flag(1'b0, erdy);
	endtask
	initial begin
		void'($urandom(32'hcdae13ad));
		boot(2'b10, 1'b0);
		probe(cb, miss);
		phys3(8'd1);
		probe(cb, hit);
		probe(cb + 12'h1, hit);
		probe(cb + 12'h2, miss);
		probe(12'h0ff, hit);
		probe(12'h1ff, hit);
		probe(12'h104, hit);
		probe(12'h105, miss);
		probe(12'h201, miss);
		@(negedge ref_clk);
		cmp_flag(1'b0, ovf);
		cmp_flag(1'b0, cfg_err);
		boot(2'b00, 1'b0);
		phys3(8'd17);
		@(posedge ref_clk);
		msw <= 2'b10;
		w1b <= 12'h180;
		probe(12'h105, hit);
		probe(12'h10f, hit);
		probe(12'h110, miss);
		probe(12'h20f, hit);
		probe(12'h0ff, hit);
		@(negedge ref_clk);
		cmp_flag(1'b1, ovf);
		boot(2'b11, 1'b1);
		send(5'b10110, 8'd2, 12'h300, 12'h300);
		send(5'b00100, 8'd1, 12'h400, 12'h000);
		send(5'b00110, 8'd1, 12'h501, 12'h000);
		send(5'b10111, 8'd1, 12'h310, 12'h310);
		wait_for(1'b1);
		cmp_flag(1'b1, cfg_err);
		probe(12'h301, hit);
		probe(12'h302, miss);
		probe(12'h310, hit);
		probe(12'h311, miss);
		probe(12'h400, miss);
		probe(12'h501, miss);
		probe(12'h100, miss);
		probe(12'h0ff, miss);
		probe(cb, hit);
		boot(2'b01, 1'b0);
		send(5'b10100, 8'd2, 12'h104, 12'h104);
		send(5'b10101, 8'd1, 12'h300, 12'h300);
		wait_for(1'b1);
		cmp_flag(1'b1, cfg_err);
		probe(12'h100, hit);
		probe(12'h20f, hit);
		probe(12'h300, hit);
		probe(12'h210, miss);
		probe(12'h1ff, miss);
		repeat (3) @(posedge ref_clk);
		close_out();
	end
endmodule
`default_nettype wire
